// file: core/peepc_host.sv
// host controller that drives the page-write parallel eeprom pins
`timescale 1ns/1ps
module peepc_host #(
  parameter int PROG_CYCLES = peepc_pkg::PROG_CYC,
  parameter int LOAD_CYCLES = peepc_pkg::LOAD_CYC,
  parameter int PAGE_BYTES = 64,
  parameter logic [12:0] LOCK_A0 = 13'h1555,
  parameter logic [12:0] LOCK_A1 = 13'h0aaa,
  parameter logic [12:0] LOCK_A2 = 13'h1555,
  parameter logic [7:0] LOCK_D0 = 8'haa,
  parameter logic [7:0] LOCK_D1 = 8'h55,
  parameter logic [7:0] LOCK_D2_ON = 8'ha0,
  parameter logic [7:0] LOCK_D2_OFF = 8'h80,
  parameter logic [7:0] LOCK_D3_OFF = 8'haa,
  parameter logic [7:0] LOCK_D4_OFF = 8'h55,
  parameter logic [7:0] LOCK_D5_OFF = 8'h20
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire peepc_pkg::peepc_req_t req_i,
  input wire logic req_valid_i,
  input wire logic lock_prefix_i,
  output logic req_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic done_o,
  output logic timeout_o,
  output peepc_pkg::peepc_pins_t pins_o,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic [7:0] data_i
);
  localparam int CW = peepc_pkg::CNT_W;

  // refused at elaboration: counters too narrow or page out of range
  if (PAGE_BYTES < 1 || PAGE_BYTES > 64 || PROG_CYCLES < 2 ||
      PROG_CYCLES >= (1 << CW) || LOAD_CYCLES <= peepc_pkg::GAP_CYC) begin : g_param_check
    $error("peepc_host: unsupported parameters");
  end

  // ****************************************************
  // state and pin registers
  // ****************************************************
  typedef enum logic [3:0] {
    S_IDLE, S_PREFIX, S_WLOW, S_WGAP, S_WAIT_NEXT, S_RLOW, S_POLL_LOW, S_POLL_GAP
  } peepc_state_t;

  peepc_state_t state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] watch;
  logic [2:0] seq_idx;
  logic [2:0] seq_len;
  logic seq_then_data;
  logic [7:0] last_data;
  logic [12:0] last_addr;
  logic last_id;
  logic [7:0] prev_poll;
  logic poll_first;
  logic poll_tog_only;
  logic [7:0] sync1;
  logic [7:0] sync2;

  // pin data reaches logic through two stages
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= data_i;
      sync2 <= sync1;
    end
  end

  // ****************************************************
  // lock sequence table
  // ****************************************************
  function automatic logic [20:0] seq_word(input logic off, input logic [2:0] i);
    logic [12:0] a;
    logic [7:0] d;
    a = (i == 3'h1 || i == 3'h4) ? LOCK_A1 : (i == 3'h0 || i == 3'h3) ? LOCK_A0 : LOCK_A2;
    d = LOCK_D0;
    unique case (i)
      3'h0: d = LOCK_D0;
      3'h1: d = LOCK_D1;
      3'h2: d = off ? LOCK_D2_OFF : LOCK_D2_ON;
      3'h3: d = LOCK_D3_OFF;
      3'h4: d = LOCK_D4_OFF;
      default: d = LOCK_D5_OFF;
    endcase
    return {a, d};
  endfunction

  logic seq_off;
  wire [20:0] seq_cur = seq_word(seq_off, seq_idx);
  // lock commands store no data, so only the toggle bit tells the end
  wire poll_busy = !poll_first &&
    ((sync2[peepc_pkg::TOGGLE_BIT] != prev_poll[peepc_pkg::TOGGLE_BIT]) ||
     (!poll_tog_only &&
      sync2[peepc_pkg::POLL_BIT] != last_data[peepc_pkg::POLL_BIT]));
  wire same_page = req_i.addr[12:6] == last_addr[12:6] && req_i.id_space == last_id;
  wire next_ok = req_valid_i && req_i.cmd == peepc_pkg::PEEPC_CMD_WRITE && same_page;
  wire [CW-1:0] strobe_n = CW'(peepc_pkg::STROBE_CYC);
  wire [CW-1:0] gap_n = CW'(peepc_pkg::GAP_CYC);
  wire [CW-1:0] acc_n = CW'(peepc_pkg::ACCESS_CYC);

  // ****************************************************
  // sequencer
  // ****************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      cnt <= '0;
      watch <= '0;
      seq_idx <= 3'h0;
      seq_len <= 3'h0;
      seq_off <= 1'b0;
      seq_then_data <= 1'b0;
      last_data <= 8'h00;
      last_addr <= 13'h0000;
      last_id <= 1'b0;
      prev_poll <= 8'h00;
      poll_first <= 1'b1;
      poll_tog_only <= 1'b0;
      pins_o <= '{chip_select_n: 1'b1, output_enable_n: 1'b1, write_strobe_n: 1'b1,
                  id_select_address_line: 1'b0, addr: 13'h0000};
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      req_ready_o <= 1'b0;
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
      done_o <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      done_o <= 1'b0;
      timeout_o <= 1'b0;
      cnt <= (cnt != '0) ? cnt - CW'(1) : cnt;
      watch <= (watch != '0) ? watch - CW'(1) : watch;
      unique case (state)
        S_IDLE: begin
          req_ready_o <= 1'b1;
          if (req_valid_i && req_ready_o) begin
            req_ready_o <= 1'b0;
            last_addr <= req_i.addr;
            last_id <= req_i.id_space;
            last_data <= req_i.data;
            pins_o.id_select_address_line <= req_i.id_space;
            poll_tog_only <= req_i.cmd != peepc_pkg::PEEPC_CMD_WRITE;
            if (req_i.cmd == peepc_pkg::PEEPC_CMD_READ) begin
              pins_o.addr <= req_i.addr;
              pins_o.chip_select_n <= 1'b0;
              pins_o.output_enable_n <= 1'b0;
              cnt <= acc_n + CW'(2);
              state <= S_RLOW;
            end else begin
              seq_off <= req_i.cmd == peepc_pkg::PEEPC_CMD_LOCK_OFF;
              seq_len <= (req_i.cmd == peepc_pkg::PEEPC_CMD_LOCK_OFF) ? 3'h6 : 3'h3;
              seq_then_data <= req_i.cmd == peepc_pkg::PEEPC_CMD_WRITE;
              seq_idx <= 3'h0;
              state <= (req_i.cmd != peepc_pkg::PEEPC_CMD_WRITE || lock_prefix_i) ?
                       S_PREFIX : S_WLOW;
              if (req_i.cmd == peepc_pkg::PEEPC_CMD_WRITE && !lock_prefix_i) begin
                pins_o.addr <= req_i.addr;
                data_o <= req_i.data;
                pins_o.output_enable_n <= 1'b1;
                pins_o.chip_select_n <= 1'b0;
                pins_o.write_strobe_n <= 1'b0;
                data_oe_o <= 1'b1;
                cnt <= strobe_n;
              end
            end
          end
        end
        S_PREFIX: begin
          // sequence bytes go at page-load pace
          pins_o.addr <= seq_cur[20:8];
          data_o <= seq_cur[7:0];
          pins_o.id_select_address_line <= 1'b0;
          pins_o.chip_select_n <= 1'b0;
          pins_o.write_strobe_n <= 1'b0;
          data_oe_o <= 1'b1;
          cnt <= strobe_n;
          seq_idx <= seq_idx + 3'h1;
          state <= S_WLOW;
        end
        S_WLOW: begin
          // held long enough to pass the glitch filter
          if (cnt == '0) begin
            pins_o.write_strobe_n <= 1'b1;
            pins_o.chip_select_n <= 1'b1;
            cnt <= gap_n;
            state <= S_WGAP;
          end
        end
        S_WGAP: begin
          if (cnt == '0) begin
            data_oe_o <= 1'b0;
            watch <= CW'(LOAD_CYCLES) - gap_n - CW'(1);
            if (seq_idx != 3'h0 && seq_idx < seq_len) begin
              state <= S_PREFIX;
            end else if (seq_idx != 3'h0 && seq_then_data) begin
              seq_idx <= 3'h0;
              pins_o.addr <= last_addr;
              pins_o.id_select_address_line <= last_id;
              data_o <= last_data;
              pins_o.chip_select_n <= 1'b0;
              pins_o.write_strobe_n <= 1'b0;
              data_oe_o <= 1'b1;
              cnt <= strobe_n;
              state <= S_WLOW;
            end else begin
              seq_idx <= 3'h0;
              req_ready_o <= seq_then_data;
              state <= S_WAIT_NEXT;
            end
          end
        end
        S_WAIT_NEXT: begin
          // more bytes of the same page, else let the window lapse
          if (req_valid_i && req_ready_o && next_ok && !req_i.last && watch != '0) begin
            req_ready_o <= 1'b0;
            last_data <= req_i.data;
            last_addr <= req_i.addr;
            pins_o.addr <= req_i.addr;
            data_o <= req_i.data;
            pins_o.chip_select_n <= 1'b0;
            pins_o.write_strobe_n <= 1'b0;
            data_oe_o <= 1'b1;
            cnt <= strobe_n;
            state <= S_WLOW;
          end else if ((req_valid_i && req_ready_o && next_ok) || watch == '0) begin
            if (req_valid_i && req_ready_o && next_ok && watch != '0) begin
              last_data <= req_i.data;
              last_addr <= req_i.addr;
              pins_o.addr <= req_i.addr;
              data_o <= req_i.data;
              pins_o.chip_select_n <= 1'b0;
              pins_o.write_strobe_n <= 1'b0;
              data_oe_o <= 1'b1;
              cnt <= strobe_n;
              seq_then_data <= 1'b0;
              state <= S_WLOW;
            end else begin
              pins_o.addr <= last_addr;
              poll_first <= 1'b1;
              watch <= CW'(PROG_CYCLES);
              state <= S_POLL_GAP;
            end
            req_ready_o <= 1'b0;
          end else if (!seq_then_data) begin
            req_ready_o <= 1'b0;
            if (watch == '0 || seq_idx == 3'h0) begin
              pins_o.addr <= last_addr;
              poll_first <= 1'b1;
              watch <= CW'(PROG_CYCLES);
              cnt <= CW'(LOAD_CYCLES);
              state <= S_POLL_GAP;
            end
          end
        end
        S_POLL_GAP: begin
          // programming starts once the load window lapses
          if (cnt == '0) begin
            pins_o.chip_select_n <= 1'b0;
            pins_o.output_enable_n <= 1'b0;
            cnt <= acc_n + CW'(2);
            state <= S_POLL_LOW;
          end
        end
        S_POLL_LOW: begin
          if (cnt == '0) begin
            pins_o.chip_select_n <= 1'b1;
            pins_o.output_enable_n <= 1'b1;
            prev_poll <= sync2;
            poll_first <= 1'b0;
            cnt <= gap_n;
            if (!poll_first && !poll_busy) begin
              done_o <= 1'b1;
              state <= S_IDLE;
            end else if (watch == '0) begin
              timeout_o <= 1'b1;
              state <= S_IDLE;
            end else begin
              state <= S_POLL_GAP;
            end
          end
        end
        S_RLOW: begin
          if (cnt == '0) begin
            pins_o.chip_select_n <= 1'b1;
            pins_o.output_enable_n <= 1'b1;
            rd_data_o <= sync2;
            rd_valid_o <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// file: shared/peepc_pkg.sv
// constants and carrier types for the parallel eeprom host controller
// Operation
// - write is strobe pulse, output enable high
// - next byte within load window
// - host keeps page bits fixed per load
// - three-write sequence engages lock
// - prefix sequence allows locked write
// - lock commands follow page timing
// - raised id line reaches id bytes
package peepc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 50;
  // strobe low time, ns; must clear the device noise filter
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  // read access time, ns
  localparam int ACCESS_NS = 150;
  localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  // gap between page bytes, ns
  localparam int GAP_NS = 100;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_MS = 10;
  localparam int PROG_CYC = PROG_MS * CLK_MHZ * 1000;
  localparam int LOAD_US = 150;
  localparam int LOAD_CYC = LOAD_US * CLK_MHZ;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam logic [ADDR_W-1:0] ID_BASE = 13'h1fc0;
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    PEEPC_CMD_READ,
    PEEPC_CMD_WRITE,
    PEEPC_CMD_LOCK_ON,
    PEEPC_CMD_LOCK_OFF
  } peepc_cmd_t;

  typedef struct packed {
    peepc_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic id_space;
    logic last;
  } peepc_req_t;

  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic id_select_address_line;
    logic [ADDR_W-1:0] addr;
  } peepc_pins_t;
endpackage

// file: tb/peepc_dev_model.sv
// behavioural page-write eeprom seen only through its pins
`timescale 1ns/1ps
module peepc_dev_model #(
  parameter int LOAD_NS = 600,
  parameter int PROG_NS = 1000,
  parameter logic [20:0] S0 = {13'h1555, 8'haa},
  parameter logic [20:0] S1 = {13'h0aaa, 8'h55},
  parameter logic [20:0] S2 = {13'h1555, 8'ha0},
  // tail of the six-write unlock sequence; its head is S0, S1
  parameter logic [20:0] F2 = {13'h1555, 8'h80},
  parameter logic [20:0] F3 = {13'h1555, 8'haa},
  parameter logic [20:0] F4 = {13'h0aaa, 8'h55},
  parameter logic [20:0] F5 = {13'h1555, 8'h20}
) (
  input wire peepc_pkg::peepc_pins_t pins_i,
  input wire logic [7:0] host_d_i,
  input wire logic host_oe_i,
  output logic [7:0] bus_o
);
  logic [7:0] mem [0:16383];
  logic [7:0] pg [0:63];
  logic [63:0] hit;
  logic [13:0] wa;
  logic [7:0] pa;
  logic [7:0] last_d;
  logic busy, tog, lock, loading;
  int sq, oq;
  time tf, stamp;
  wire sel = !pins_i.chip_select_n;
  wire wr = sel && !pins_i.write_strobe_n && pins_i.output_enable_n;
  wire rd = sel && !pins_i.output_enable_n && pins_i.write_strobe_n;
  wire idsp = pins_i.id_select_address_line && (&pins_i.addr[12:6]);
  wire [7:0] dout = busy ? {~last_d[7], tog, 6'h00} : mem[{idsp, pins_i.addr}];
  wire [20:0] cur = {wa[12:0], host_d_i};
  wire seq_hit = (sq == 0 && cur == S0) || (sq == 1 && cur == S1) || (sq == 2 && cur == S2);
  wire off_hit = (oq == 0 && cur == S0) || (oq == 1 && cur == S1) || (oq == 2 && cur == F2) ||
    (oq == 3 && cur == F3) || (oq == 4 && cur == F4) || (oq == 5 && cur == F5);
  // released bus shows the inverse of the last byte, never a stale copy
  assign bus_o = host_oe_i ? host_d_i : (rd ? dout : ~last_d);
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {busy, tog, lock, loading} = 4'h0;
    sq = 0;
    oq = 0;
    hit = '0;
    last_d = 8'h00;
  end
  always @(posedge wr) begin
    wa = {idsp, pins_i.addr};
    tf = $time;
  end
  always @(negedge wr) begin
    if (!busy && $time - tf >= 15) begin
      stamp = $time;
      loading = 1;
      last_d = host_d_i;
      if (seq_hit || off_hit) begin
        if (seq_hit) sq++;
        if (off_hit) oq++;
      end else begin
        pa = wa[13:6];
        pg[wa[5:0]] = host_d_i;
        hit[wa[5:0]] = 1'b1;
      end
    end
  end
  always @(negedge rd) if (busy) tog = !tog;
  always begin
    #10;
    if (loading && $time - stamp > LOAD_NS) begin
      loading = 0;
      if (!lock || sq == 3) begin
        foreach (hit[i]) if (hit[i]) mem[{pa, i[5:0]}] = pg[i];
      end
      if (sq == 3) lock = 1;
      if (oq == 6) lock = 0;
      sq = 0;
      oq = 0;
      hit = '0;
      busy = 1;
      #PROG_NS;
      busy = 0;
    end
  end
endmodule

// file: tb/peepc_host_monitor.sv
// pin-level checks on the eeprom host controller
`timescale 1ns/1ps
module peepc_host_monitor (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_ready_o,
  input wire logic rd_valid_o,
  input wire logic done_o,
  input wire logic timeout_o,
  input wire peepc_pkg::peepc_pins_t pins_o,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire we_lo = !pins_o.write_strobe_n;
  chk_we_oe_high: assert property (we_lo |-> pins_o.output_enable_n && !pins_o.chip_select_n)
    else $error("strobe low while output enabled or deselected");
  chk_drive_safe: assert property (data_oe_o |-> pins_o.output_enable_n)
    else $error("host drives data while device may drive");
  // short pulses would be swallowed by the device filter
  chk_pulse_width: assert property ($fell(pins_o.write_strobe_n) |-> we_lo[*5])
    else $error("write strobe too short");
  chk_addr_hold: assert property (we_lo && $past(we_lo) |-> $stable(pins_o.addr))
    else $error("address moved during strobe");
  chk_data_hold: assert property (we_lo && $past(we_lo) |-> data_oe_o && $stable(data_o))
    else $error("data moved during strobe");
  chk_data_after: assert property ($rose(pins_o.write_strobe_n) |-> data_oe_o)
    else $error("data released before strobe end");
  chk_strobe_gap: assert property ($rose(pins_o.write_strobe_n) |=> !we_lo[*4])
    else $error("strobes too close");
  chk_ready_idle: assert property (we_lo |-> !req_ready_o)
    else $error("ready during strobe");
  chk_done_once: assert property (done_o |=> !done_o && !timeout_o)
    else $error("done not a single pulse");
  chk_rd_pulse: assert property (rd_valid_o |=> !rd_valid_o)
    else $error("read valid not a single pulse");
  cover property (done_o);
  cover property (rd_valid_o);
  cover property (we_lo && pins_o.id_select_address_line);
endmodule
bind peepc_host peepc_host_monitor u_mon (.clock_i(clock_i), .rst_i(rst_i),
  .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .done_o(done_o),
  .timeout_o(timeout_o), .pins_o(pins_o), .data_o(data_o), .data_oe_o(data_oe_o));

// file: tb/peepc_host_tb.sv
// testbench for the eeprom host controller against the device model
`timescale 1ns/1ps
module peepc_host_tb;
  logic clock_i, rst_i, req_valid_i, lock_prefix_i;
  logic req_ready_o, rd_valid_o, done_o, timeout_o, data_oe_o;
  logic [7:0] rd_data_o, data_o, data_i;
  peepc_pkg::peepc_req_t req_i;
  peepc_pkg::peepc_pins_t pins_o;
  int n_mismatch, cmp_count;
  peepc_host #(.PROG_CYCLES(200), .LOAD_CYCLES(40)) u_dut (.clock_i(clock_i), .rst_i(rst_i),
    .req_i(req_i), .req_valid_i(req_valid_i), .lock_prefix_i(lock_prefix_i),
    .req_ready_o(req_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .done_o(done_o), .timeout_o(timeout_o), .pins_o(pins_o), .data_o(data_o),
    .data_oe_o(data_oe_o), .data_i(data_i));
  peepc_dev_model u_dev (.pins_i(pins_o), .host_d_i(data_o), .host_oe_i(data_oe_o),
    .bus_o(data_i));
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input peepc_pkg::peepc_cmd_t c, input logic [13:0] a,
                      input logic [7:0] d, input logic l);
    int k;
    k = 0;
    @(negedge clock_i);
    req_i = '{c, a[12:0], d, a[13], l};
    req_valid_i = 1'b1;
    // ready seen at the falling edge is what the next rising edge samples
    while (req_ready_o !== 1'b1 && k < 200) begin
      @(negedge clock_i);
      k++;
    end
    if (k == 200) begin
      n_mismatch++;
      wrap_up();
    end
    @(negedge clock_i);
    req_valid_i = 1'b0;
  endtask
  task automatic wait_ev(input bit rd);
    int k;
    k = 0;
    while (!(rd ? rd_valid_o === 1'b1 : done_o === 1'b1) && k < 3000) begin
      @(negedge clock_i);
      k++;
      if (timeout_o === 1'b1) check(8'h01, 8'h00);
    end
    if (k == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [13:0] a, input logic [7:0] exp);
    send(peepc_pkg::PEEPC_CMD_READ, a, 8'h00, 1'b1);
    wait_ev(1);
    check(rd_data_o, exp);
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic l);
    send(peepc_pkg::PEEPC_CMD_WRITE, a, d, l);
    if (l) wait_ev(0);
  endtask
  task automatic s_byte;
    wr(14'h0123, 8'h3c, 1'b1);
    rd(14'h0123, 8'h3c);
  endtask
  task automatic s_page;
    wr(14'h0043, 8'h11, 1'b0);
    wr(14'h0040, 8'h22, 1'b0);
    wr(14'h0043, 8'h33, 1'b0);
    wr(14'h007f, 8'h44, 1'b1);
    rd(14'h0043, 8'h33);
    rd(14'h0040, 8'h22);
    rd(14'h007f, 8'h44);
    rd(14'h0041, 8'hff);
  endtask
  task automatic s_window;
    wr(14'h0200, 8'h5a, 1'b0);
    wait_ev(0);
    rd(14'h0200, 8'h5a);
  endtask
  task automatic s_id;
    wr(14'h3fc5, 8'h77, 1'b1);
    rd(14'h3fc5, 8'h77);
    rd(14'h1fc5, 8'hff);
  endtask
  task automatic s_lock;
    send(peepc_pkg::PEEPC_CMD_LOCK_ON, 14'h0000, 8'h00, 1'b1);
    wait_ev(0);
    wr(14'h0300, 8'h99, 1'b1);
    rd(14'h0300, 8'hff);
    lock_prefix_i = 1'b1;
    wr(14'h0300, 8'h66, 1'b1);
    lock_prefix_i = 1'b0;
    rd(14'h0300, 8'h66);
    rd(14'h0aaa, 8'hff);
    send(peepc_pkg::PEEPC_CMD_LOCK_OFF, 14'h0000, 8'h00, 1'b1);
    wait_ev(0);
    wr(14'h0300, 8'h5a, 1'b1);
    rd(14'h0300, 8'h5a);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    lock_prefix_i = 1'b0;
    req_i = '0;
    repeat (10) @(negedge clock_i);
    rst_i = 1'b0;
    @(negedge clock_i);
    s_byte();
    s_page();
    s_window();
    s_id();
    s_lock();
    wrap_up();
  end
endmodule
